// file: hdl/modbus_gate_pkg.sv
package modbus_gate_pkg;

  localparam int CLK_HZ = 250_000_000;
  localparam int OVERSAMPLE = 16;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RS485_ADDR = 8'h04;
  localparam logic [7:0] OFS_RS485_COMM = 8'h08;
  localparam logic [7:0] OFS_WR_PW_LO = 8'h0c;
  localparam logic [7:0] OFS_WR_PW_HI = 8'h10;
  localparam logic [7:0] OFS_CMD_PW = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  localparam int CTRL_USB_ORDER = 0;
  localparam int CTRL_RS485_ORDER = 1;
  localparam int CTRL_LOCK_ASSIGNED = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  localparam int COMM_BAUD_LSB = 0;
  localparam int COMM_DATA7 = 4;
  localparam int COMM_TWO_STOP = 5;
  localparam int COMM_PARITY_LSB = 6;
  localparam logic [7:0] COMM_RESET = 8'h04;
  localparam logic [7:0] RS485_ADDR_RESET = 8'h01;

  localparam int PW_CHARS = 7;
  localparam int PW_BITS = PW_CHARS * 8;
  localparam logic [PW_BITS-1:0] PW_BLANK = 56'h0;

  localparam logic [13:0] CMD_PW_RESET = 14'h007b;
  localparam logic [13:0] CMD_PW_MAX = 14'h270f;

  localparam logic PORT_USB = 1'b0;
  localparam logic PORT_RS485 = 1'b1;
  localparam logic LOW_WORD_FIRST = 1'b0;
  localparam logic HIGH_WORD_FIRST = 1'b1;

  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_REFUSED = 8'h04;

  typedef enum logic [2:0] {
    KIND_READ,
    KIND_PARAM_WRITE,
    KIND_COUNTER_RESET,
    KIND_COMMAND,
    KIND_WRITE_PASSWORD,
    KIND_COMMAND_PASSWORD
  } reqKind_t;

  // Cycles per oversample tick for each baud selection.
  function automatic logic [15:0] baudDivisor(input logic [3:0] sel);
    int baud;
    case (sel)
      4'h0: baud = 1200;
      4'h1: baud = 2400;
      4'h2: baud = 4800;
      4'h3: baud = 9600;
      4'h4: baud = 19200;
      4'h5: baud = 38400;
      4'h6: baud = 57600;
      default: baud = 115200;
    endcase
    return 16'(CLK_HZ / (OVERSAMPLE * baud));
  endfunction : baudDivisor

endpackage : modbus_gate_pkg

// file: hdl/baud_tick_gen.sv
module baud_tick_gen
  import modbus_gate_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] baudSel,
  output logic tick
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [3:0] sel_reg;
  wire logic [15:0] divisor = baudDivisor(baudSel);
  wire logic wrap = (count_reg >= divisor - 16'h0001) || (sel_reg != baudSel);

  // A change of rate restarts the count so no stretched tick appears.
  assign count_next = wrap ? 16'h0000 : count_reg + 16'h0001;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 16'h0000;
      sel_reg <= 4'h0;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      sel_reg <= baudSel;
      tick <= wrap && (sel_reg == baudSel);
    end
  end

endmodule : baud_tick_gen

// file: hdl/modbus_slave_access_gate.sv
// Contract
// - Slave only on both ports: answer master requests, never initiate.
// - Reads of measures and states never need a password.
// - Write password up to seven characters; blank default disables protection.
// - Non-blank password: refuse writes, resets, commands until password written.
// - Command password ranges 0 to 9999, default 123.
// - Nonzero command password must precede every single command.
// - Active remote command lock input blocks port commands; the code blocks them only while ctrl bit CTRL_LOCK_ASSIGNED is set.
// - USB word order: 0 low word first, 1 high word first.
// - RS485 has its own independent word order setting.
// - RS485 answers only its address, uses configured baud and framing.
module modbus_slave_access_gate
  import modbus_gate_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic remoteCommandLockInput,
  input wire logic reqValid,
  input wire logic reqPort,
  input wire logic [7:0] reqSlave,
  input wire logic [2:0] reqKind,
  input wire logic [1:0] reqIndex,
  input wire logic [15:0] reqData,
  input wire logic [31:0] reqValue,
  output logic respValid,
  output logic respPort,
  output logic respException,
  output logic [7:0] respCode,
  output logic [15:0] respData,
  output logic paramWrite,
  output logic counterReset,
  output logic commandExec,
  output logic [1:0] actionIndex,
  output logic [15:0] actionData,
  output logic rs485BitTick,
  output logic rs485DataBits7,
  output logic rs485TwoStop,
  output logic [1:0] rs485Parity
);

  logic [2:0] ctrl_reg;
  logic [7:0] rsAddr_reg;
  logic [7:0] comm_reg;
  logic [PW_BITS-1:0] wrPw_reg;
  logic [13:0] cmdPw_reg;
  logic [7:0] refusals_reg;
  logic [1:0] unlocked_reg;
  logic [1:0] armed_reg;
  // Each port assembles its own entry, so one master cannot finish another's unlock.
  logic [PW_BITS-1:0] pwEntry_reg [2];

  // APB decode: zero wait states, unmapped offsets answer with pslverr.
  wire logic apbAccess = psel && penable;
  wire logic apbWrite = apbAccess && pwrite;
  wire logic hitCtrl = paddr == OFS_CTRL;
  wire logic hitAddr = paddr == OFS_RS485_ADDR;
  wire logic hitComm = paddr == OFS_RS485_COMM;
  wire logic hitPwLo = paddr == OFS_WR_PW_LO;
  wire logic hitPwHi = paddr == OFS_WR_PW_HI;
  wire logic hitCmdPw = paddr == OFS_CMD_PW;
  wire logic hitStatus = paddr == OFS_STATUS;
  wire logic mapped = hitCtrl || hitAddr || hitComm || hitPwLo || hitPwHi || hitCmdPw || hitStatus;
  wire logic pwConfigWrite = apbWrite && (hitPwLo || hitPwHi);
  // The lock input is taken as synchronous; an asynchronous source needs a synchroniser first.
  wire logic lockActive = ctrl_reg[CTRL_LOCK_ASSIGNED] && remoteCommandLockInput;

  assign pready = 1'b1;
  assign pslverr = apbAccess && !mapped;
  assign prdata = hitCtrl ? {29'h0, ctrl_reg} :
                  hitAddr ? {24'h0, rsAddr_reg} :
                  hitComm ? {24'h0, comm_reg} :
                  hitPwLo ? wrPw_reg[31:0] :
                  hitPwHi ? {8'h0, wrPw_reg[PW_BITS-1:32]} :
                  hitCmdPw ? {18'h0, cmdPw_reg} :
                  hitStatus ? {16'h0, refusals_reg, 2'b00, lockActive, 1'b0,
                               armed_reg, unlocked_reg} :
                  32'h0;

  // Request classification.
  wire logic isRead = reqKind == KIND_READ;
  wire logic isParam = reqKind == KIND_PARAM_WRITE;
  wire logic isCounter = reqKind == KIND_COUNTER_RESET;
  wire logic isCmd = reqKind == KIND_COMMAND;
  wire logic isWrPw = reqKind == KIND_WRITE_PASSWORD;
  wire logic isCmdPw = reqKind == KIND_COMMAND_PASSWORD;
  wire logic isBad = !(isRead || isParam || isCounter || isCmd || isWrPw || isCmdPw);

  // Requests on RS485 for another slave are dropped without a reply.
  wire logic take = reqValid && (reqPort == PORT_USB || reqSlave == rsAddr_reg);
  wire logic pwBlank = wrPw_reg == PW_BLANK;
  wire logic portUnlocked = pwBlank || unlocked_reg[reqPort];
  wire logic cmdPwNeeded = cmdPw_reg != 14'h0000;
  wire logic cmdPwMatch = {2'b00, cmdPw_reg} == reqData;
  wire logic cmdAllowed = portUnlocked && !lockActive && (!cmdPwNeeded || armed_reg[reqPort]);
  wire logic cmdPwAllowed = portUnlocked && !lockActive && cmdPwMatch;
  wire logic refuse = ((isParam || isCounter) && !portUnlocked) || (isCmd && !cmdAllowed) ||
                      (isCmdPw && !cmdPwAllowed);
  wire logic exception = isBad || refuse;
  wire logic [7:0] excCode = isBad ? EXC_ILLEGAL_FUNCTION :
                             (isCmdPw && portUnlocked && !lockActive) ? EXC_ILLEGAL_VALUE :
                             EXC_REFUSED;
  // Word order only swaps which half an index selects; the value itself is untouched.
  wire logic portOrder = reqPort ? ctrl_reg[CTRL_RS485_ORDER] : ctrl_reg[CTRL_USB_ORDER];
  wire logic selHigh = reqIndex[0] ^ (portOrder == HIGH_WORD_FIRST);
  wire logic [15:0] readWord = selHigh ? reqValue[31:16] : reqValue[15:0];
  wire logic [15:0] replyWord = isRead ? readWord : reqData;
  // A value above the limit is refused whole rather than clipped to a different code.
  wire logic cmdPwOk = pwdata[13:0] <= CMD_PW_MAX;

  // Per-port password entry and unlock/arm state.
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic [PW_BITS-1:0] entryNext;
      wire logic hit = take && (reqPort == p);
      wire logic pwHit = hit && isWrPw;
      wire logic armSet = hit && isCmdPw && cmdPwAllowed;
      wire logic armClear = hit && (isCmd || (isCmdPw && !cmdPwAllowed));

      always_comb begin
        entryNext = pwEntry_reg[p];
        case (reqIndex)
          2'd0: entryNext[15:0] = reqData;
          2'd1: entryNext[31:16] = reqData;
          2'd2: entryNext[47:32] = reqData;
          default: entryNext[PW_BITS-1:48] = reqData[7:0];
        endcase
      end

      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pwEntry_reg[p] <= PW_BLANK;
          unlocked_reg[p] <= 1'b0;
          armed_reg[p] <= 1'b0;
        end else begin
          if (pwHit) begin
            pwEntry_reg[p] <= entryNext;
          end
          // A master's unlock in the same cycle as a new local password wins.
          if (pwHit) begin
            unlocked_reg[p] <= entryNext == wrPw_reg;
          end else if (pwConfigWrite) begin
            unlocked_reg[p] <= 1'b0;
          end
          // One arming covers exactly one command, accepted or refused.
          if (armSet) begin
            armed_reg[p] <= 1'b1;
          end else if (armClear) begin
            armed_reg[p] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= CTRL_RESET;
      rsAddr_reg <= RS485_ADDR_RESET;
      comm_reg <= COMM_RESET;
      wrPw_reg <= PW_BLANK;
      cmdPw_reg <= CMD_PW_RESET;
    end else if (apbWrite) begin
      if (hitCtrl) ctrl_reg <= pwdata[2:0];
      if (hitAddr) rsAddr_reg <= pwdata[7:0];
      if (hitComm) comm_reg <= pwdata[7:0];
      if (hitPwLo) wrPw_reg[31:0] <= pwdata;
      if (hitPwHi) wrPw_reg[PW_BITS-1:32] <= pwdata[23:0];
      // Out-of-range command passwords are ignored, keeping the old value.
      if (hitCmdPw && cmdPwOk && pwdata[31:14] == 18'h0) cmdPw_reg <= pwdata[13:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      respValid <= 1'b0;
      respPort <= PORT_USB;
      respException <= 1'b0;
      respCode <= 8'h00;
      respData <= 16'h0000;
      paramWrite <= 1'b0;
      counterReset <= 1'b0;
      commandExec <= 1'b0;
      actionIndex <= 2'd0;
      actionData <= 16'h0000;
      refusals_reg <= 8'h00;
    end else begin
      respValid <= take;
      respException <= take && exception;
      paramWrite <= take && isParam && !refuse;
      counterReset <= take && isCounter && !refuse;
      commandExec <= take && isCmd && !refuse;
      // Reply port, code and data and the action fields follow only a taken request, so they hold between requests.
      if (take) begin
        respPort <= reqPort;
        respCode <= exception ? excCode : 8'h00;
        respData <= replyWord;
        actionIndex <= reqIndex;
        actionData <= reqData;
      end
      // The refusal count wraps at 255, so software should read it as a rate.
      if (take && refuse) refusals_reg <= refusals_reg + 8'h01;
    end
  end

  assign rs485DataBits7 = comm_reg[COMM_DATA7];
  assign rs485TwoStop = comm_reg[COMM_TWO_STOP];
  assign rs485Parity = comm_reg[COMM_PARITY_LSB +: 2];

  // The tick restarts on a rate change, so the first period at a new rate is full.
  baud_tick_gen u_baud (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .baudSel(comm_reg[COMM_BAUD_LSB +: 4]),
    .tick(rs485BitTick)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_reply_only_asked: assert property (respValid |-> $past(take))
    else $error("Reply without a request.");
  a_read_open: assert property (take && isRead |=> respValid && !respException)
    else $error("Read was refused.");
  a_blank_open: assert property (take && isParam && pwBlank |=> paramWrite)
    else $error("Blank password blocked a write.");
  a_locked_write: assert property (take && isParam && !portUnlocked
      |=> respException && !paramWrite && respCode == EXC_REFUSED)
    else $error("Write passed without password.");
  a_cmd_pw_range: assert property (cmdPw_reg <= CMD_PW_MAX)
    else $error("Command password out of range.");
  a_cmd_needs_arm: assert property (take && isCmd && cmdPwNeeded && !armed_reg[reqPort]
      |=> !commandExec ##1 !(commandExec && respPort == $past(reqPort, 2)))
    else $error("Command without command password.");
  a_lock_blocks: assert property (take && isCmd && lockActive |=> !commandExec && respException)
    else $error("Command passed under lock.");
  a_usb_order: assert property (take && isRead && reqPort == PORT_USB && !reqIndex[0]
      |=> respData == ($past(ctrl_reg[CTRL_USB_ORDER]) ? $past(reqValue[31:16])
                       : $past(reqValue[15:0])))
    else $error("USB word order wrong.");
  a_rs485_order: assert property (take && isRead && reqPort == PORT_RS485 && reqIndex[0]
      |=> respData == ($past(ctrl_reg[CTRL_RS485_ORDER]) ? $past(reqValue[15:0])
                       : $past(reqValue[31:16])))
    else $error("RS485 word order wrong.");
  a_foreign_addr: assert property (reqValid && reqPort == PORT_RS485
      && reqSlave != rsAddr_reg |=> !respValid)
    else $error("Answered a foreign address.");
  a_refuse_silent: assert property (take && refuse
      |=> respException && !paramWrite && !counterReset && !commandExec)
    else $error("Refused request had effects.");

  // Further checks of the reply path one cycle behind the request, plus the bit tick and the APB password registers.
  a_armed_exec: assert property (take && isCmd && armed_reg[reqPort] && portUnlocked
      && !lockActive |=> commandExec)
    else $error("Armed command was not executed.");
  a_free_cmd: assert property (take && isCmd && !cmdPwNeeded && portUnlocked
      && !lockActive |=> commandExec)
    else $error("Command refused without a command password set.");
  a_open_counter: assert property (take && isCounter && portUnlocked |=> counterReset)
    else $error("Open counter reset was refused.");
  a_locked_counter: assert property (take && isCounter && !portUnlocked
      |=> !counterReset && respException)
    else $error("Counter reset passed without password.");
  a_bad_kind: assert property (take && isBad
      |=> respException && respCode == EXC_ILLEGAL_FUNCTION)
    else $error("Illegal request kind not refused.");
  a_wrong_cmd_pw: assert property (take && isCmdPw && portUnlocked && !lockActive
      && !cmdPwMatch |=> respException && respCode == EXC_ILLEGAL_VALUE)
    else $error("Wrong command password not reported.");
  a_read_no_action: assert property (take && isRead
      |=> !paramWrite && !counterReset && !commandExec)
    else $error("Read caused an action.");
  a_tick_single: assert property (rs485BitTick |=> !rs485BitTick)
    else $error("Bit tick longer than one cycle.");
  a_resp_port: assert property (take |=> respPort == $past(reqPort))
    else $error("Reply on the wrong port.");
  a_cmd_pw_kept: assert property (apbWrite && hitCmdPw && pwdata > 32'(CMD_PW_MAX)
      |=> $stable(cmdPw_reg))
    else $error("Out of range command password stored.");
  a_pw_apb_relock: assert property (pwConfigWrite && !(take && isWrPw)
      |=> unlocked_reg == 2'b00)
    else $error("New password left a port unlocked.");
  a_action_pulses: assert property (paramWrite || counterReset || commandExec
      |-> respValid && !respException)
    else $error("Action without an accepted reply.");
  a_exc_code_zero: assert property (respValid && !respException |-> respCode == 8'h00)
    else $error("Exception code on a normal reply.");
  a_foreign_no_action: assert property (reqValid && reqPort == PORT_RS485
      && reqSlave != rsAddr_reg |=> !paramWrite && !counterReset && !commandExec)
    else $error("Foreign request caused an action.");

  c_unlock: cover property (take && isWrPw ##1 unlocked_reg != 2'b00);
  c_armed_cmd: cover property (take && isCmdPw && cmdPwAllowed ##1 take && isCmd ##1 commandExec);
  c_refused: cover property (respException && respCode == EXC_REFUSED);
  c_high_first: cover property (take && isRead && portOrder == HIGH_WORD_FIRST);
  c_rs485_read: cover property (take && isRead && reqPort == PORT_RS485);

endmodule : modbus_slave_access_gate

// file: bench/modbus_master_model.sv
module modbus_master_model
  import modbus_gate_pkg::*;
(
  input wire logic ref_clk,
  output logic reqValid,
  output logic reqPort,
  output logic [7:0] reqSlave,
  output logic [2:0] reqKind,
  output logic [1:0] reqIndex,
  output logic [15:0] reqData,
  output logic [31:0] reqValue
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reqValid = 1'b0;
    reqPort = PORT_USB;
    reqSlave = 8'h00;
    reqKind = 3'h0;
    reqIndex = 2'h0;
    reqData = 16'h0000;
    reqValue = 32'h0000_0000;
  end

  // One request per call, held for exactly one taken edge.
  task automatic send(input logic p, input logic [7:0] s, input logic [2:0] k,
                      input logic [1:0] i, input logic [15:0] d, input logic [31:0] v);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqPort <= p;
    reqSlave <= s;
    reqKind <= k;
    reqIndex <= i;
    reqData <= d;
    reqValue <= v;
    @(posedge ref_clk);
    reqValid <= 1'b0;
    // The data and value fields are inverted on release so that a late capture cannot pass for a match.
    reqData <= ~d;
    reqValue <= ~v;
    #1;
  endtask : send
endmodule : modbus_master_model

// file: bench/modbus_slave_access_gate_test.sv
module modbus_slave_access_gate_test
  import modbus_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic remoteCommandLockInput = 1'b0;
  logic pready, pslverr, reqValid, reqPort, respValid, respPort, respException, err;
  logic paramWrite, counterReset, commandExec, rs485BitTick, rs485DataBits7, rs485TwoStop;
  logic [31:0] prdata, reqValue, rd;
  logic [7:0] reqSlave, respCode;
  logic [2:0] reqKind;
  logic [1:0] reqIndex, actionIndex, rs485Parity;
  logic [15:0] reqData, respData, actionData;
  logic [63:0] pw = 64'h0047464544434241;
  int failures = 0;
  int num_checks = 0;
  int n;

  modbus_slave_access_gate i_modbus_slave_access_gate (
    .ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .remoteCommandLockInput, .reqValid, .reqPort, .reqSlave, .reqKind,
    .reqIndex, .reqData, .reqValue, .respValid, .respPort, .respException, .respCode,
    .respData, .paramWrite, .counterReset, .commandExec, .actionIndex, .actionData,
    .rs485BitTick, .rs485DataBits7, .rs485TwoStop, .rs485Parity
  );

  modbus_master_model i_modbus_master_model (
    .ref_clk, .reqValid, .reqPort, .reqSlave, .reqKind, .reqIndex, .reqData, .reqValue
  );

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write settle so callers see register-driven outputs updated.
    #1;
  endtask : apb

  task automatic rq(input logic p, input logic [7:0] s, input logic [2:0] k,
                    input logic [1:0] i, input logic [15:0] d);
    i_modbus_master_model.send(p, s, k, i, d, 32'h9abc1234);
  endtask : rq

  task automatic resp(input string w, input logic v, input logic e, input logic [7:0] c);
    check({w, " valid"}, 32'(respValid), 32'(v));
    if (v) begin
      check({w, " exc"}, 32'(respException), 32'(e));
      check({w, " code"}, 32'(respCode), 32'(c));
    end
  endtask : resp

  task automatic armCmd(input logic ok);
    rq(PORT_USB, 8'h00, KIND_COMMAND_PASSWORD, 2'h0, 16'd123);
    rq(PORT_USB, 8'h00, KIND_COMMAND, 2'h0, 16'h0022);
    check("exec", 32'(commandExec), 32'(ok));
    resp("cmd", 1'b1, !ok, ok ? 8'h00 : EXC_REFUSED);
  endtask : armCmd

  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #100000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    apb(1'b0, OFS_RS485_ADDR, 32'h0);
    check("addr", rd, 32'h01);
    apb(1'b0, OFS_RS485_COMM, 32'h0);
    check("comm", rd, 32'h04);
    apb(1'b0, OFS_CMD_PW, 32'h0);
    check("cmdpw", rd, 32'h7b);
    apb(1'b0, OFS_WR_PW_LO, 32'h0);
    check("wrpw", rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    for (int o = 0; o < 4; o++) begin
      apb(1'b1, OFS_CTRL, 32'(o));
      for (int p = 0; p < 2; p++) begin
        rq(p[0], 8'h01, KIND_READ, 2'h0, 16'h0);
        resp("read", 1'b1, 1'b0, 8'h00);
        check("port", 32'(respPort), 32'(p));
        check("word0", 32'(respData), o[p] ? 32'h9abc : 32'h1234);
        rq(p[0], 8'h01, KIND_READ, 2'h1, 16'h0);
        check("word1", 32'(respData), o[p] ? 32'h1234 : 32'h9abc);
      end
    end
    apb(1'b1, OFS_RS485_ADDR, 32'h05);
    rq(PORT_RS485, 8'h01, KIND_READ, 2'h0, 16'h0);
    resp("foreign", 1'b0, 1'b0, 8'h00);
    @(posedge ref_clk);
    #1;
    check("idle", 32'(respValid), 32'h0);
    rq(PORT_RS485, 8'h05, KIND_READ, 2'h0, 16'h0);
    resp("own addr", 1'b1, 1'b0, 8'h00);
    rq(PORT_USB, 8'h00, 3'h6, 2'h0, 16'h0);
    resp("bad kind", 1'b1, 1'b1, EXC_ILLEGAL_FUNCTION);
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, OFS_RS485_COMM, 32'((p << 6) | (p << 4)));
      check("parity", 32'(rs485Parity), 32'(p));
      check("data7", 32'(rs485DataBits7), 32'(p & 1));
      check("stop2", 32'(rs485TwoStop), 32'(p >> 1));
    end
    apb(1'b1, OFS_RS485_COMM, 32'h07);
    // Skip the edges that may still carry a tick of the old rate.
    repeat (2) @(posedge ref_clk);
    n = 0;
    while (rs485BitTick !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    n = 1;
    while (rs485BitTick !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    check("tick", n, CLK_HZ / (OVERSAMPLE * 115200));
    apb(1'b1, OFS_CTRL, 32'h0);
    rq(PORT_USB, 8'h00, KIND_COMMAND, 2'h0, 16'h0011);
    check("bare exec", 32'(commandExec), 32'h0);
    resp("bare", 1'b1, 1'b1, EXC_REFUSED);
    armCmd(1'b1);
    rq(PORT_USB, 8'h00, KIND_COMMAND, 2'h0, 16'h0011);
    resp("reuse", 1'b1, 1'b1, EXC_REFUSED);
    rq(PORT_USB, 8'h00, KIND_COMMAND_PASSWORD, 2'h0, 16'd124);
    resp("bad pw", 1'b1, 1'b1, EXC_ILLEGAL_VALUE);
    @(posedge ref_clk);
    remoteCommandLockInput <= 1'b1;
    armCmd(1'b1);
    apb(1'b1, OFS_CTRL, 32'h4);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("lock bit", rd, 32'h0320);
    armCmd(1'b0);
    @(posedge ref_clk);
    remoteCommandLockInput <= 1'b0;
    armCmd(1'b1);
    apb(1'b1, OFS_CMD_PW, 32'd9999);
    apb(1'b1, OFS_CMD_PW, 32'd10000);
    apb(1'b0, OFS_CMD_PW, 32'h0);
    check("pw max", rd, 32'h270f);
    apb(1'b1, OFS_CMD_PW, 32'h0);
    rq(PORT_USB, 8'h00, KIND_COMMAND, 2'h0, 16'h0033);
    check("free exec", 32'(commandExec), 32'h1);
    rq(PORT_USB, 8'h00, KIND_PARAM_WRITE, 2'h2, 16'h5a5a);
    check("blank wr", 32'(paramWrite), 32'h1);
    check("wr data", 32'({actionIndex, actionData}), 32'h25a5a);
    apb(1'b1, OFS_WR_PW_LO, pw[31:0]);
    apb(1'b1, OFS_WR_PW_HI, pw[63:32]);
    rq(PORT_USB, 8'h00, KIND_PARAM_WRITE, 2'h1, 16'h1111);
    check("locked wr", 32'(paramWrite), 32'h0);
    resp("locked wr", 1'b1, 1'b1, EXC_REFUSED);
    rq(PORT_USB, 8'h00, KIND_COUNTER_RESET, 2'h0, 16'h0);
    check("locked rst", 32'(counterReset), 32'h0);
    for (int i = 0; i < 4; i++) begin
      rq(PORT_USB, 8'h00, KIND_WRITE_PASSWORD, 2'(i), pw[16*i +: 16]);
    end
    rq(PORT_USB, 8'h00, KIND_PARAM_WRITE, 2'h1, 16'h1111);
    check("open wr", 32'(paramWrite), 32'h1);
    rq(PORT_USB, 8'h00, KIND_COUNTER_RESET, 2'h0, 16'h0);
    check("open rst", 32'(counterReset), 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("status", rd, 32'h0701);
    give_verdict();
  end
endmodule : modbus_slave_access_gate_test
